// *** hw/tpf_core.sv ***
// Overview of operation
// - counter starts at zero counting up; each period has an up and down half
// - each compare from 1 to period-1 matches once in each half, giving half the duty each
// - duty buffer is copied into compare A at every underflow
// - with auto dead time, compare B is recomputed whenever compare A changes
// - pin A starts low, toggles on compare A match, cycle-end field sets level at period end
// - pin B starts high, toggles on compare B match, cycle-end field sets level at period end
// - force code 11b holds pin A high from next underflow, matches ignored
// - force code 10b holds pin A low from next underflow, matches ignored
// - pin B force codes behave the same, matches on compare B ignored
// - force code 00b returns pin A to compare control at next underflow
// - on release pin A level follows cycle-end field and release-select bit
// - on release pin B level follows cycle-end field and release-select bit
// - an underflow interrupt pulse is raised at every counter underflow
// - counting begins on a software start command
// - compares, interrupts and buffer transfers continue while pins are forced
// - force set while stopped applies at start only with force-at-start set
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module tpf_core import tpf_pkg::*; #(
   parameter logic [DW-1:0] PERIOD_RESET = RST_PERIOD
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [DW-1:0] wb_dat_i,
   input  wire logic [3:0]    wb_sel_i,
   output logic               wb_ack_o,
   output logic [DW-1:0]      wb_dat_o,
   output logic               pwm_out_a_o,
   output logic               pwm_out_b_o,
   output logic               underflow_irq_o
);

   typedef struct packed {
      tpf_cnt_e      st;
      logic          auto_dt;
      logic [DW-1:0] count;
      logic [DW-1:0] period;
      logic [DW-1:0] duty_buf;
      logic [DW-1:0] cmp_a;
      logic [DW-1:0] cmp_b;
      logic [DW-1:0] dt_up;
      logic [DW-1:0] dt_down;
      logic [7:0]    force_ctl;
      logic [7:0]    io_ctl;
      logic          irq;
   } tpf_core_s;

   tpf_core_s    s_r;
   tpf_core_s    s_nxt;
   tpf_acc_s     acc;
   logic [DW-1:0] rd_data;
   tpf_pin_cfg_s cfg_a;
   tpf_pin_cfg_s cfg_b;
   tpf_pin_evt_s evt_a;
   tpf_pin_evt_s evt_b;
   logic         forced_a;
   logic         forced_b;
   logic         running;
   logic         trough;
   logic         start_evt;
   logic         wr_ctrl;

   // byte-lane merge of a bus write
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] wd,
                                           input logic [3:0] sel);
      logic [DW-1:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // negative-phase compare derived from positive-phase compare
   function automatic logic [DW-1:0] dead_time_b(input logic [DW-1:0] a, input logic [DW-1:0] dt);
      dead_time_b = a - dt;
   endfunction

   // true when the access is a write to the given register offset
   function automatic logic wr_hit(input tpf_acc_s a, input logic [AW-1:0] ofs);
      wr_hit = a.wr && (a.adr == ofs);
   endfunction

   // bus slave: decode, ack and read-data register
   tpf_wb_slave u_wbs (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wb_cyc_i  (wb_cyc_i),
      .wb_stb_i  (wb_stb_i),
      .wb_we_i   (wb_we_i),
      .wb_adr_i  (wb_adr_i),
      .wb_dat_i  (wb_dat_i),
      .wb_sel_i  (wb_sel_i),
      .rd_data_i (rd_data),
      .wb_ack_o  (wb_ack_o),
      .wb_dat_o  (wb_dat_o),
      .acc_o     (acc)
   );

   // counter events shared by both pins
   always_comb begin
      running   = (s_r.st != CNT_STOP);
      trough    = (s_r.st == CNT_DOWN) && (s_r.count <= CNT_ONE);
      wr_ctrl   = wr_hit(acc, OFS_CTRL) && acc.sel[0];
      start_evt = wr_ctrl && acc.wdata[CTRL_RUN_BIT] && !running;
   end

   // per-pin configuration and events
   assign cfg_a.force_mode     = s_r.force_ctl[FA_LSB +: 2];
   assign cfg_a.release_sel    = s_r.force_ctl[RSA_BIT];
   assign cfg_a.force_at_start = s_r.force_ctl[FSA_BIT];
   assign cfg_a.cycle_ctl      = s_r.io_ctl[IOA_CYC_LSB +: 2];
   assign cfg_b.force_mode     = s_r.force_ctl[FB_LSB +: 2];
   assign cfg_b.release_sel    = s_r.force_ctl[RSB_BIT];
   assign cfg_b.force_at_start = s_r.force_ctl[FSB_BIT];
   assign cfg_b.cycle_ctl      = s_r.io_ctl[IOB_CYC_LSB +: 2];

   // matches are plain equality, so each value from 1 to period-1 hits once per half
   assign evt_a.start  = start_evt;
   assign evt_a.match  = running && !start_evt && (s_r.count == s_r.cmp_a);
   assign evt_a.trough = trough;
   assign evt_b.start  = start_evt;
   assign evt_b.match  = running && !start_evt && (s_r.count == s_r.cmp_b);
   assign evt_b.trough = trough;

   // pin A starts low
   tpf_pin_ctrl #(
      .START_LVL (1'b0)
   ) u_pin_a (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cfg_i    (cfg_a),
      .evt_i    (evt_a),
      .pin_o    (pwm_out_a_o),
      .forced_o (forced_a)
   );

   // pin B starts high
   tpf_pin_ctrl #(
      .START_LVL (1'b1)
   ) u_pin_b (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cfg_i    (cfg_b),
      .evt_i    (evt_b),
      .pin_o    (pwm_out_b_o),
      .forced_o (forced_b)
   );

   // register read mux, unmapped reads return zero
   always_comb begin
      rd_data = RST_WORD;
      case (acc.adr)
         OFS_CTRL: begin
            rd_data[CTRL_RUN_BIT]    = running;
            rd_data[CTRL_AUTODT_BIT] = s_r.auto_dt;
         end
         OFS_PERIOD:  rd_data = s_r.period;
         OFS_DUTYBUF: rd_data = s_r.duty_buf;
         OFS_CMP_A:   rd_data = s_r.cmp_a;
         OFS_CMP_B:   rd_data = s_r.cmp_b;
         OFS_DT_UP:   rd_data = s_r.dt_up;
         OFS_DT_DOWN: rd_data = s_r.dt_down;
         OFS_FORCE:   rd_data[7:0] = s_r.force_ctl;
         OFS_PIN_IO:  rd_data[7:0] = s_r.io_ctl;
         OFS_COUNT:   rd_data = s_r.count;
         OFS_STATUS: begin
            rd_data[ST_RUN_BIT]  = running;
            rd_data[ST_DOWN_BIT] = (s_r.st == CNT_DOWN);
            rd_data[ST_FA_BIT]   = forced_a;
            rd_data[ST_FB_BIT]   = forced_b;
         end
         default: rd_data = RST_WORD;
      endcase
   end

   // counter state machine, register writes and buffer transfer
   always_comb begin
      s_nxt     = s_r;
      s_nxt.irq = trough;

      // triangle counter
      case (s_r.st)
         CNT_STOP: begin
            if (start_evt) begin
               s_nxt.st    = CNT_UP;
               s_nxt.count = CNT_ZERO;
            end
         end
         CNT_UP: begin
            if (s_r.count >= s_r.period) begin
               s_nxt.st    = CNT_DOWN;
               s_nxt.count = s_r.count - CNT_ONE;
            end else begin
               s_nxt.count = s_r.count + CNT_ONE;
            end
         end
         CNT_DOWN: begin
            if (trough) begin
               s_nxt.st    = CNT_UP;
               s_nxt.count = CNT_ZERO;
            end else begin
               s_nxt.count = s_r.count - CNT_ONE;
            end
         end
         default: begin
            s_nxt.st = CNT_STOP;
         end
      endcase

      // control register: run and auto dead time
      if (wr_ctrl) begin
         s_nxt.auto_dt = acc.wdata[CTRL_AUTODT_BIT];
         if (!acc.wdata[CTRL_RUN_BIT]) begin
            s_nxt.st = CNT_STOP;
         end
      end

      // plain data registers
      if (wr_hit(acc, OFS_PERIOD)) begin
         s_nxt.period = merge(s_r.period, acc.wdata, acc.sel);
      end
      if (wr_hit(acc, OFS_DUTYBUF)) begin
         s_nxt.duty_buf = merge(s_r.duty_buf, acc.wdata, acc.sel);
      end
      if (wr_hit(acc, OFS_DT_UP)) begin
         s_nxt.dt_up = merge(s_r.dt_up, acc.wdata, acc.sel);
      end
      if (wr_hit(acc, OFS_DT_DOWN)) begin
         s_nxt.dt_down = merge(s_r.dt_down, acc.wdata, acc.sel);
      end
      if (wr_hit(acc, OFS_FORCE) && acc.sel[0]) begin
         s_nxt.force_ctl = acc.wdata[7:0];
      end
      if (wr_hit(acc, OFS_PIN_IO) && acc.sel[0]) begin
         s_nxt.io_ctl = acc.wdata[7:0];
      end

      // compare registers by direct write
      if (wr_hit(acc, OFS_CMP_A)) begin
         s_nxt.cmp_a = merge(s_r.cmp_a, acc.wdata, acc.sel);
      end
      if (wr_hit(acc, OFS_CMP_B) && !s_r.auto_dt) begin
         s_nxt.cmp_b = merge(s_r.cmp_b, acc.wdata, acc.sel);
      end

      // buffer transfer at the trough wins over a direct write
      if (trough) begin
         s_nxt.cmp_a = s_r.duty_buf;
      end

      // dead time follows every update of compare A
      if (s_nxt.auto_dt && (s_nxt.cmp_a != s_r.cmp_a || s_nxt.auto_dt != s_r.auto_dt)) begin
         s_nxt.cmp_b = dead_time_b(s_nxt.cmp_a, s_r.dt_up);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{st:        CNT_STOP,
                  auto_dt:   1'b0,
                  count:     CNT_ZERO,
                  period:    PERIOD_RESET,
                  duty_buf:  RST_WORD,
                  cmp_a:     RST_WORD,
                  cmp_b:     RST_WORD,
                  dt_up:     RST_WORD,
                  dt_down:   RST_WORD,
                  force_ctl: RST_FORCE,
                  io_ctl:    RST_IO,
                  irq:       1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign underflow_irq_o = s_r.irq;

endmodule

// *** pkg/tpf_pkg.sv ***
package tpf_pkg;

   // bus geometry
   localparam int DW = 32;
   localparam int AW = 8;

   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
   localparam logic [AW-1:0] OFS_PERIOD   = 8'h04;
   localparam logic [AW-1:0] OFS_DUTYBUF  = 8'h08;
   localparam logic [AW-1:0] OFS_CMP_A    = 8'h0c;
   localparam logic [AW-1:0] OFS_CMP_B    = 8'h10;
   localparam logic [AW-1:0] OFS_DT_UP    = 8'h14;
   localparam logic [AW-1:0] OFS_DT_DOWN  = 8'h18;
   localparam logic [AW-1:0] OFS_FORCE    = 8'h1c;
   localparam logic [AW-1:0] OFS_PIN_IO   = 8'h20;
   localparam logic [AW-1:0] OFS_COUNT    = 8'h24;
   localparam logic [AW-1:0] OFS_STATUS   = 8'h28;

   // control register bits
   localparam int CTRL_RUN_BIT    = 0;
   localparam int CTRL_AUTODT_BIT = 1;

   // duty_force_control field positions
   localparam int FA_LSB  = 0;
   localparam int RSA_BIT = 2;
   localparam int FSA_BIT = 3;
   localparam int FB_LSB  = 4;
   localparam int RSB_BIT = 6;
   localparam int FSB_BIT = 7;

   // pin_io_control cycle-end field positions
   localparam int IOA_CYC_LSB = 2;
   localparam int IOB_CYC_LSB = 6;

   // status register bits
   localparam int ST_RUN_BIT  = 0;
   localparam int ST_DOWN_BIT = 1;
   localparam int ST_FA_BIT   = 2;
   localparam int ST_FB_BIT   = 3;

   // force-duty codes
   localparam logic [1:0] FORCE_NONE = 2'h0;
   localparam logic [1:0] FORCE_LOW  = 2'h2;
   localparam logic [1:0] FORCE_HIGH = 2'h3;

   // cycle-end output control codes
   localparam logic [1:0] CYC_RETAIN = 2'h0;
   localparam logic [1:0] CYC_LOW    = 2'h1;
   localparam logic [1:0] CYC_HIGH   = 2'h2;
   localparam logic [1:0] CYC_TOGGLE = 2'h3;

   // reset values and counter constants
   localparam logic [DW-1:0] CNT_ZERO   = 32'h0000_0000;
   localparam logic [DW-1:0] CNT_ONE    = 32'h0000_0001;
   localparam logic [DW-1:0] RST_WORD   = 32'h0000_0000;
   localparam logic [7:0]    RST_FORCE  = 8'h00;
   localparam logic [7:0]    RST_IO     = 8'h00;

   // carrier timing: one carrier is two counter halves
   localparam int CLK_PERIOD_NS = 20;
   localparam int CARRIER_NS    = 1_000_000;
   localparam logic [DW-1:0] RST_PERIOD = 32'(CARRIER_NS / CLK_PERIOD_NS / 2);

   // counter states
   typedef enum logic [2:0] {
      CNT_STOP = 3'h1,
      CNT_UP   = 3'h2,
      CNT_DOWN = 3'h4
   } tpf_cnt_e;

   // one register access from the bus slave
   typedef struct packed {
      logic          wr;
      logic [AW-1:0] adr;
      logic [DW-1:0] wdata;
      logic [3:0]    sel;
   } tpf_acc_s;

   // configuration of one pin
   typedef struct packed {
      logic [1:0] force_mode;
      logic       release_sel;
      logic       force_at_start;
      logic [1:0] cycle_ctl;
   } tpf_pin_cfg_s;

   // counter events for one pin
   typedef struct packed {
      logic start;
      logic match;
      logic trough;
   } tpf_pin_evt_s;

endpackage

// *** hw/tpf_wb_slave.sv ***
`timescale 1ns/1ps
module tpf_wb_slave import tpf_pkg::*; (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [DW-1:0] wb_dat_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [DW-1:0] rd_data_i,
   output logic               wb_ack_o,
   output logic [DW-1:0]      wb_dat_o,
   output tpf_acc_s           acc_o
);

   typedef struct packed {
      logic          ack;
      logic [DW-1:0] dat;
   } tpf_wbs_s;

   tpf_wbs_s s_r;
   tpf_wbs_s s_nxt;
   logic     req;

   // ack one cycle after the request, then drop
   always_comb begin
      req       = wb_cyc_i & wb_stb_i;
      s_nxt     = s_r;
      s_nxt.ack = req & ~s_r.ack;
      if (req && !wb_we_i && !s_r.ack) begin
         s_nxt.dat = rd_data_i;   // read data held while ack is high
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{ack: 1'b0, dat: RST_WORD};
      end else begin
         s_r <= s_nxt;
      end
   end

   // write takes effect at the edge that samples ack
   assign acc_o.wr    = req & wb_we_i & s_r.ack;
   assign acc_o.adr   = wb_adr_i;
   assign acc_o.wdata = wb_dat_i;
   assign acc_o.sel   = wb_sel_i;
   assign wb_ack_o    = s_r.ack;
   assign wb_dat_o    = s_r.dat;

endmodule

// *** hw/tpf_pin_ctrl.sv ***
`timescale 1ns/1ps
module tpf_pin_ctrl import tpf_pkg::*; #(
   parameter logic START_LVL = 1'b0
) (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  tpf_pin_cfg_s cfg_i,
   input  tpf_pin_evt_s evt_i,
   output logic        pin_o,
   output logic        forced_o
);

   typedef struct packed {
      logic       out;
      logic       cmp_lvl;
      logic [1:0] force_mode;
   } tpf_pin_s;

   tpf_pin_s s_r;
   tpf_pin_s s_nxt;
   logic     lvl;

   // only 10b and 11b force the pin
   function automatic logic [1:0] forcing(input logic [1:0] code);
      forcing = code[1] ? code : FORCE_NONE;
   endfunction

   // level at the end of a carrier period
   function automatic logic cycle_end(input logic l, input logic [1:0] ctl);
      case (ctl)
         CYC_LOW:    cycle_end = 1'b0;
         CYC_HIGH:   cycle_end = 1'b1;
         CYC_TOGGLE: cycle_end = ~l;
         default:    cycle_end = l;
      endcase
   endfunction

   // compare level runs on while forced, pin follows force or compare
   always_comb begin
      s_nxt = s_r;
      lvl   = s_r.cmp_lvl;
      if (evt_i.start) begin
         lvl              = START_LVL;
         s_nxt.force_mode = cfg_i.force_at_start ? forcing(cfg_i.force_mode) : FORCE_NONE;
      end else begin
         if (evt_i.trough) begin
            if (s_r.force_mode[1] && !cfg_i.force_mode[1] && !cfg_i.release_sel) begin
               lvl = s_r.out;
            end
            lvl              = cycle_end(lvl, cfg_i.cycle_ctl);
            s_nxt.force_mode = forcing(cfg_i.force_mode);
         end
         if (evt_i.match) begin
            lvl = ~lvl;
         end
      end
      s_nxt.cmp_lvl = lvl;
      s_nxt.out     = s_nxt.force_mode[1] ? s_nxt.force_mode[0] : s_nxt.cmp_lvl;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{out: START_LVL, cmp_lvl: START_LVL, force_mode: FORCE_NONE};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_o    = s_r.out;
   assign forced_o = s_r.force_mode[1];

endmodule

// *** test/tpf_core_props.sv ***
`timescale 1ns/1ps
module tpf_core_props import tpf_pkg::*; #(
   parameter logic [DW-1:0] PERIOD_RESET = RST_PERIOD
) (
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [DW-1:0] wb_dat_i,
   input wire logic [3:0]    wb_sel_i,
   input wire logic          wb_ack_o,
   input wire logic [DW-1:0] wb_dat_o,
   input wire logic          pwm_out_a_o,
   input wire logic          pwm_out_b_o,
   input wire logic          underflow_irq_o
);
   logic run_r;
   logic ctl_wr;

   // accepted write of the run bit
   assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == OFS_CTRL && wb_sel_i[0];

   // run state as software last set it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
      end else if (ctl_wr) begin
         run_r <= wb_dat_i[CTRL_RUN_BIT];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // bus answers one cycle after the request
   AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   AST_UNMAPPED: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h3c
                                  |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   // pin start levels and trough pulse
   AST_RST_LEVELS: assert property ($fell(rst_i) |-> !pwm_out_a_o && pwm_out_b_o && !underflow_irq_o)
      else $error("wrong levels after reset");
   AST_IRQ_PULSE: assert property (underflow_irq_o |=> !underflow_irq_o [*3])
      else $error("underflow pulse too long or too close");
   // stopped counter leaves pins and pulse alone
   AST_STOP_HOLD: assert property (!run_r && !$past(run_r) && !$past(run_r, 2)
                                   |-> $stable(pwm_out_a_o) && $stable(pwm_out_b_o))
      else $error("pin moved while stopped");
   AST_STOP_NO_IRQ: assert property (!run_r && !$past(run_r) && !$past(run_r, 2) |-> !underflow_irq_o)
      else $error("underflow while stopped");
endmodule

bind tpf_core tpf_core_props #(.PERIOD_RESET(PERIOD_RESET)) u_tpf_core_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o),
   .underflow_irq_o(underflow_irq_o));

// *** test/tpf_gate_model.sv ***
`timescale 1ns/1ps
module tpf_gate_model (
   input  wire logic        clk_i,
   input  wire logic        pwm_a_i,
   input  wire logic        pwm_b_i,
   input  wire logic        irq_i,
   output logic [15:0]      hi_a_o,
   output logic [15:0]      lo_b_o
);
   logic [15:0] acc_a = 16'h0000;
   logic [15:0] acc_b = 16'h0000;

   initial hi_a_o = 16'h0000;
   initial lo_b_o = 16'h0000;

   // gate on-times per carrier, window opens at each underflow pulse
   always @(posedge clk_i) begin
      if (irq_i) begin
         hi_a_o <= acc_a;
         lo_b_o <= acc_b;
         acc_a <= {15'h0000, pwm_a_i};
         acc_b <= {15'h0000, !pwm_b_i};
      end else begin
         acc_a <= acc_a + {15'h0000, pwm_a_i};
         acc_b <= acc_b + {15'h0000, !pwm_b_i};
      end
   end
endmodule

// *** test/tb_tpf_core.sv ***
`timescale 1ns/1ps
module tb_tpf_core import tpf_pkg::*;;
   localparam int P = 16;
   localparam int DT = 2;
   logic          clk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          wb_cyc_i = 1'b0;
   logic          wb_stb_i = 1'b0;
   logic          wb_we_i = 1'b0;
   logic [AW-1:0] wb_adr_i = 8'h00;
   logic [DW-1:0] wb_dat_i = 32'h0000_0000;
   logic [3:0]    wb_sel_i = 4'hf;
   logic          wb_ack_o;
   logic [DW-1:0] wb_dat_o;
   logic          pwm_out_a_o;
   logic          pwm_out_b_o;
   logic          underflow_irq_o;
   logic [15:0]   hi_a;
   logic [15:0]   lo_b;
   logic [DW-1:0] rd;
   int            mismatches = 0;
   int            checks = 0;
   // duty sequence: 0 compare driven, 1 zero duty, 2 full duty
   int            duty [7] = '{8, 4, 12, 4, 8, 6, 8};
   int            mode [7] = '{0, 0, 2, 0, 1, 0, 0};
   logic [AW-1:0] rofs [6] = '{OFS_PERIOD, OFS_DT_UP, OFS_FORCE, OFS_PIN_IO, OFS_STATUS, 8'h3c};
   logic [DW-1:0] rrst [6] = '{32'(P), RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD};

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   tpf_core #(.PERIOD_RESET(32'(P))) u_tpf_core (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o),
      .underflow_irq_o(underflow_irq_o));

   tpf_gate_model u_tpf_gate_model (
      .clk_i(clk_i), .pwm_a_i(pwm_out_a_o), .pwm_b_i(pwm_out_b_o), .irq_i(underflow_irq_o),
      .hi_a_o(hi_a), .lo_b_o(lo_b));

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // compare with an optional one-cycle slack
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input int slack);
      checks++;
      if (!(got === exp || (slack != 0 && (got === exp + 1 || got === exp - 1)))) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic wishbone cycle, held until ack
   task automatic bus(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      bus(1'b0, a, RST_WORD);
      chk(rd, exp, 0);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (underflow_irq_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         mismatches++;
         $display("[FAIL] %0t no underflow", $time);
      end
   endtask

   // force word for a sequence step, release select set on both pins
   function automatic logic [DW-1:0] frc(input int m);
      return {24'h000000, 2'b01, (m == 1) ? FORCE_HIGH : (m == 2) ? FORCE_LOW : FORCE_NONE,
              2'b01, (m == 1) ? FORCE_LOW : (m == 2) ? FORCE_HIGH : FORCE_NONE};
   endfunction

   // expected on-time per carrier, d is the extra dead time
   function automatic logic [DW-1:0] exp_on(input int i, input int d);
      if (mode[i] == 1)
         return 32'h0000_0000;
      if (mode[i] == 2)
         return 32'(2 * P);
      return 32'(2 * (P - duty[i] + d));
   endfunction

   // main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, pwm_out_a_o}, 32'h0, 0);
      chk({31'h0, pwm_out_b_o}, 32'h1, 0);
      for (int i = 0; i < 6; i++) rdchk(rofs[i], rrst[i]);
      wr(OFS_FORCE, 32'hffff_ffff);
      rdchk(OFS_FORCE, 32'h0000_00ff);
      wr(OFS_COUNT, 32'h0000_0005);
      rdchk(OFS_COUNT, CNT_ZERO);
      wr(8'h3c, 32'h1234_5678);
      rdchk(8'h3c, RST_WORD);
      wr(OFS_PIN_IO, 32'(CYC_RETAIN));
      wr(OFS_DT_UP, 32'(DT));
      wr(OFS_DT_DOWN, 32'(DT));
      wr(OFS_FORCE, frc(0));
      wr(OFS_CTRL, 32'h0000_0002);
      wr(OFS_CMP_A, 32'(duty[0]));
      rdchk(OFS_CMP_B, 32'(duty[0] - DT));
      wr(OFS_CMP_B, 32'h0000_0003);
      rdchk(OFS_CMP_B, 32'(duty[0] - DT));
      wr(OFS_DUTYBUF, 32'(duty[0]));
      wr(OFS_CTRL, 32'h0000_0003);
      rdchk(OFS_STATUS, 32'h0000_0001);
      // one step of the duty sequence per underflow
      for (int k = 0; k <= 7; k++) begin
         wait_irq();
         rdchk(OFS_CMP_A, 32'(duty[k > 6 ? 6 : k]));
         rdchk(OFS_CMP_B, 32'(duty[k > 6 ? 6 : k] - DT));
         if (k >= 1) begin
            chk({16'h0, hi_a}, exp_on(k - 1, 0), 1);
            chk({16'h0, lo_b}, exp_on(k - 1, DT), 1);
         end
         if (k < 6) begin
            wr(OFS_DUTYBUF, 32'(duty[k + 1]));
            wr(OFS_FORCE, frc(mode[k + 1]));
         end
      end
      // force at start applied only with its start flag
      for (int j = 0; j < 2; j++) begin
         wr(OFS_CTRL, 32'h0000_0002);
         wr(OFS_FORCE, (j == 0) ? 32'h0000_000f : 32'h0000_0007);
         wr(OFS_CTRL, 32'h0000_0003);
         repeat (3) @(posedge clk_i);
         chk({31'h0, pwm_out_a_o}, (j == 0) ? 32'h1 : 32'h0, 0);
         chk({31'h0, pwm_out_b_o}, 32'h1, 0);
         rdchk(OFS_STATUS, (j == 0) ? 32'h0000_0005 : 32'h0000_0001);
      end
      summarize();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (6000) @(posedge clk_i);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
endmodule
